/* File: src/lneg_core.sv */
// Link negotiation, MAC interface strapping and crossover control with an AXI4-Lite slave.
module lneg_core #(
	parameter int BREAK_CYC = lneg_pkg::BREAK_LINK_CYC,
	parameter int SLOT_CYCS = lneg_pkg::SLOT_CYC,
	parameter int GAP_CYC   = lneg_pkg::BURST_GAP_CYC,
	parameter int TMO_CYC   = lneg_pkg::BURST_TMO_CYC,
	parameter int SWAP_CYC  = lneg_pkg::MDIX_CYC,
	parameter int ADDR_W    = 7
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              collisionOrInterfaceStrapPinIn,
	output logic                   collisionOrInterfaceStrapPinOut,
	output logic                   collisionOrInterfaceStrapPinOe,
	output logic                   referenceClockInputSel,
	output logic                   miiOnlyPinsEn,
	input  wire logic [2:0]        modeStrap,
	input  wire logic              macTxEn,
	input  wire logic              rxActive,
	input  wire logic              rxErIn,
	output logic                   crsOut,
	output logic                   rxErOut,
	output logic                   flpTxPulse,
	input  wire logic              rxWordValid,
	input  wire logic [15:0]       rxWord,
	input  wire logic              rx100Symbols,
	input  wire logic              rxNlp,
	input  wire logic              signalDetect,
	output logic                   txRxEnable,
	output logic                   mdixSwap
);
	// ==================================================================
	// Decoding helpers
	function automatic logic isMapped(input logic [4:0] idx);
		isMapped = (idx == lneg_pkg::IDX_CTRL) || (idx == lneg_pkg::IDX_ADV)
			|| (idx == lneg_pkg::IDX_LPA) || (idx == lneg_pkg::IDX_EXP)
			|| (idx == lneg_pkg::IDX_VMODE) || (idx == lneg_pkg::IDX_SPD);
	endfunction

	function automatic logic [2:0] resolve(input logic [3:0] both);
		if (both[3])
			resolve = lneg_pkg::SPD_100F;
		else if (both[2])
			resolve = lneg_pkg::SPD_100H;
		else if (both[1])
			resolve = lneg_pkg::SPD_10F;
		else if (both[0])
			resolve = lneg_pkg::SPD_10H;
		else
			resolve = 3'h0;
	endfunction

	// ==================================================================
	// State
	lneg_pkg::lneg_state_e state_q, state_d;
	logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d, wData_q, wData_d;
	logic [4:0]  awIdx_q, awIdx_d;
	logic [3:0]  wStrb_q, wStrb_d;
	logic        awHave_q, awHave_d, wHave_q, wHave_d;
	logic        ctrlSpeed_q, ctrlSpeed_d, ctrlAnEn_q, ctrlAnEn_d;
	logic        ctrlPdn_q, ctrlPdn_d, ctrlDuplex_q, ctrlDuplex_d;
	logic [3:0]  adv_q, adv_d;
	logic [15:0] lpa_q, lpa_d;
	logic        lpAnAble_q, lpAnAble_d, pdFault_q, pdFault_d;
	logic [2:0]  spd_q, spd_d, modeLatch_q, modeLatch_d;
	logic        anDone_q, anDone_d, mdixDis_q, mdixDis_d;
	logic [31:0] cnt_q, cnt_d, slotCnt_q, slotCnt_d, gapCnt_q, gapCnt_d;
	logic [31:0] swapCnt_q, swapCnt_d;
	logic [5:0]  slotIdx_q, slotIdx_d;
	logic [1:0]  ackCnt_q, ackCnt_d;
	logic        burstOn_q, burstOn_d, ackBit_q, ackBit_d;
	logic        strapDone_q, strapDone_d, rmiiMode_q, rmiiMode_d;
	logic        pinOut_q, pinOut_d, pinOe_q, pinOe_d, crsOut_q, crsOut_d;
	logic        colOut_q, colOut_d;
	logic        rxErOut_q, rxErOut_d, flpTx_q, flpTx_d, txRxEn_q, txRxEn_d;
	logic        miiEn_q, miiEn_d, swap_q, swap_d;
	logic        wrDo, restartGo, swReset, startAn, txAct, rxAct;
	logic [15:0] txWord;
	logic [4:0]  arIdx;
	logic [2:0]  res, strapVal;

	// Code word sent in every burst.
	assign txWord = {1'b0, ackBit_q, 5'h00, adv_q, lneg_pkg::SELECTOR};
	assign arIdx  = s_axi_araddr[6:2];

	// ==================================================================
	// Next-state logic
	always_comb
	begin
		state_d = state_q;        awready_d = awready_q;  wready_d = wready_q;
		bvalid_d = bvalid_q;      bresp_d = bresp_q;      arready_d = arready_q;
		rvalid_d = rvalid_q;      rresp_d = rresp_q;      rdata_d = rdata_q;
		wData_d = wData_q;        awIdx_d = awIdx_q;      wStrb_d = wStrb_q;
		awHave_d = awHave_q;      wHave_d = wHave_q;      ctrlSpeed_d = ctrlSpeed_q;
		ctrlAnEn_d = ctrlAnEn_q;  ctrlPdn_d = ctrlPdn_q;  ctrlDuplex_d = ctrlDuplex_q;
		adv_d = adv_q;            lpa_d = lpa_q;          lpAnAble_d = lpAnAble_q;
		pdFault_d = pdFault_q;    spd_d = spd_q;          modeLatch_d = modeLatch_q;
		anDone_d = anDone_q;      mdixDis_d = mdixDis_q;  cnt_d = cnt_q + 32'h1;
		slotCnt_d = slotCnt_q;    gapCnt_d = gapCnt_q;    swapCnt_d = swapCnt_q;
		slotIdx_d = slotIdx_q;    ackCnt_d = ackCnt_q;    burstOn_d = burstOn_q;
		ackBit_d = ackBit_q;      strapDone_d = 1'b1;     rmiiMode_d = rmiiMode_q;
		swap_d = swap_q;          startAn = 1'b0;         res = resolve(adv_q & rxWord[8:5]);
		restartGo = 1'b0;         swReset = 1'b0;
		strapVal = strapDone_q ? modeLatch_q : modeStrap;
		// Strap levels are caught on the first edge after reset release.
		if (!strapDone_q)
		begin
			rmiiMode_d  = collisionOrInterfaceStrapPinIn;
			modeLatch_d = modeStrap;
		end
		// AXI4-Lite write: address and data taken in either order.
		if (s_axi_awvalid && awready_q)
		begin
			awIdx_d = s_axi_awaddr[6:2];
			awHave_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q)
		begin
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
			wHave_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		wrDo = awHave_q && wHave_q && !bvalid_q;
		if (wrDo)
		begin
			awHave_d = 1'b0;
			wHave_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = isMapped(awIdx_q) ? lneg_pkg::RESP_OK : lneg_pkg::RESP_ERR;
			if (awIdx_q == lneg_pkg::IDX_CTRL && wStrb_q[1])
			begin
				ctrlSpeed_d  = wData_q[lneg_pkg::CTRL_SPEED];
				ctrlAnEn_d   = wData_q[lneg_pkg::CTRL_ANEN];
				ctrlPdn_d    = wData_q[lneg_pkg::CTRL_PDN];
				ctrlDuplex_d = wData_q[lneg_pkg::CTRL_DUPLEX];
				// Restart and reset are pulses, never stored.
				restartGo    = wData_q[lneg_pkg::CTRL_RESTART];
				swReset      = wData_q[lneg_pkg::CTRL_RST];
			end
			// Ability writes touch only the register, not the state machine.
			if (awIdx_q == lneg_pkg::IDX_ADV)
			begin
				if (wStrb_q[0])
					adv_d[2:0] = wData_q[7:5];
				if (wStrb_q[1])
					adv_d[3] = wData_q[8];
			end
			if (awIdx_q == lneg_pkg::IDX_VMODE && wStrb_q[0])
				mdixDis_d = wData_q[lneg_pkg::VMODE_MDIXDIS];
		end
		// Capability strap: top bit enables negotiation; soft reset reuses the latch.
		if (!strapDone_q || swReset)
		begin
			ctrlAnEn_d   = strapVal[2];
			adv_d        = strapVal[2] ? (strapVal[1:0] == 2'h3 ? 4'hF :
				(strapVal[1] ? 4'hC : 4'h3)) : lneg_pkg::ADV_RST;
			ctrlSpeed_d  = strapVal[1];
			ctrlDuplex_d = strapVal[0];
		end
		awready_d = !awHave_d && !bvalid_d;
		wready_d  = !wHave_d && !bvalid_d;
		// AXI4-Lite read.
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = isMapped(arIdx) ? lneg_pkg::RESP_OK : lneg_pkg::RESP_ERR;
			case (arIdx)
				lneg_pkg::IDX_CTRL:  rdata_d = {18'h0, ctrlSpeed_q, ctrlAnEn_q, ctrlPdn_q,
					2'h0, ctrlDuplex_q, 8'h00};
				lneg_pkg::IDX_ADV:   rdata_d = {23'h0, adv_q, lneg_pkg::SELECTOR};
				lneg_pkg::IDX_LPA:   rdata_d = {16'h0, lpa_q};
				lneg_pkg::IDX_EXP:   rdata_d = {27'h0, pdFault_q, 3'h0, lpAnAble_q};
				lneg_pkg::IDX_VMODE: rdata_d = {30'h0, rmiiMode_q, mdixDis_q};
				lneg_pkg::IDX_SPD:   rdata_d = {19'h0, anDone_q, 7'h00, spd_q, 2'h0};
				default:             rdata_d = 32'h0;
			endcase
			// The fault flag clears on read; a new fault in this cycle still sets it below.
			if (arIdx == lneg_pkg::IDX_EXP)
				pdFault_d = 1'b0;
		end
		arready_d = !rvalid_d;
		// Negotiation state machine.
		case (state_q)
			lneg_pkg::ST_WAIT:
				startAn = strapDone_q;
			lneg_pkg::ST_DOWN:
				startAn = !ctrlPdn_q;
			lneg_pkg::ST_FORCED:
			begin
				spd_d = {ctrlDuplex_q, ctrlSpeed_q, ~ctrlSpeed_q};
				anDone_d = 1'b0;
				startAn = ctrlAnEn_q;
			end
			lneg_pkg::ST_BREAK:
				if (cnt_q == 32'(BREAK_CYC - 1))
					startAn = 1'b1;
			lneg_pkg::ST_ABL:
				if (rxWordValid)
				begin
					lpa_d = rxWord;
					lpAnAble_d = 1'b1;
					ackBit_d = 1'b1;
					ackCnt_d = 2'h0;
					cnt_d = 32'h0;
					state_d = lneg_pkg::ST_ACK;
				end
				else if (rx100Symbols && rxNlp)
					pdFault_d = 1'b1;
				else if (rx100Symbols || rxNlp)
				begin
					// Parallel detection is always half duplex.
					spd_d = rx100Symbols ? lneg_pkg::SPD_100H : lneg_pkg::SPD_10H;
					lpa_d = {8'h00, rx100Symbols, 1'b0, !rx100Symbols, lneg_pkg::SELECTOR};
					lpAnAble_d = 1'b0;
					anDone_d = 1'b1;
					state_d = lneg_pkg::ST_LINK;
				end
			lneg_pkg::ST_ACK:
				if (rxWordValid)
				begin
					cnt_d = 32'h0;
					if (rxWord[8:0] != lpa_q[8:0])
						startAn = 1'b1;
					else if (rxWord[lneg_pkg::ACK_BIT])
					begin
						ackCnt_d = ackCnt_q + 2'h1;
						if (ackCnt_q == 2'(lneg_pkg::ACK_WORDS - 1))
						begin
							lpa_d = rxWord;
							spd_d = res;
							anDone_d = (res != 3'h0);
							startAn = (res == 3'h0);
							state_d = lneg_pkg::ST_LINK;
						end
					end
				end
				else if (cnt_q == 32'(TMO_CYC - 1))
					startAn = 1'b1;
			lneg_pkg::ST_LINK:
				startAn = !signalDetect;
			default:
				state_d = lneg_pkg::ST_WAIT;
		endcase
		if (swReset || (!ctrlAnEn_q && ctrlAnEn_d))
			startAn = 1'b1;
		if (startAn)
		begin
			state_d = ctrlAnEn_d ? lneg_pkg::ST_ABL : lneg_pkg::ST_FORCED;
			anDone_d = 1'b0;
			ackBit_d = 1'b0;
		end
		if (!ctrlAnEn_d && state_d != lneg_pkg::ST_WAIT && state_d != lneg_pkg::ST_DOWN)
			state_d = lneg_pkg::ST_FORCED;
		if (restartGo && ctrlAnEn_d)
		begin
			state_d = lneg_pkg::ST_BREAK;
			cnt_d = 32'h0;
			anDone_d = 1'b0;
		end
		if (ctrlPdn_d)
			state_d = lneg_pkg::ST_DOWN;
		// Burst generator runs while negotiating: 33 slots then a gap.
		flpTx_d = 1'b0;
		if (state_q == lneg_pkg::ST_ABL || state_q == lneg_pkg::ST_ACK)
		begin
			if (burstOn_q)
			begin
				flpTx_d = (slotCnt_q == 32'h0) && (!slotIdx_q[0] || txWord[slotIdx_q[4:1]]);
				slotCnt_d = slotCnt_q + 32'h1;
				if (slotCnt_q == 32'(SLOT_CYCS - 1))
				begin
					slotCnt_d = 32'h0;
					slotIdx_d = slotIdx_q + 6'h01;
					if (slotIdx_q == 6'(lneg_pkg::FLP_SLOTS - 1))
					begin
						burstOn_d = 1'b0;
						gapCnt_d = 32'h0;
					end
				end
			end
			else
			begin
				gapCnt_d = gapCnt_q + 32'h1;
				if (gapCnt_q == 32'(GAP_CYC - 1))
				begin
					burstOn_d = 1'b1;
					slotIdx_d = 6'h00;
					slotCnt_d = 32'h0;
				end
			end
		end
		else
		begin
			burstOn_d = 1'b1;
			slotIdx_d = 6'h00;
			slotCnt_d = 32'h0;
		end
		// Crossover hunts by toggling until energy or link is seen.
		swapCnt_d = swapCnt_q + 32'h1;
		if (mdixDis_q)
		begin
			swap_d = 1'b0;
			swapCnt_d = 32'h0;
		end
		else if (signalDetect || state_q == lneg_pkg::ST_LINK)
			swapCnt_d = 32'h0;
		else if (swapCnt_q == 32'(SWAP_CYC - 1))
		begin
			swap_d = !swap_q;
			swapCnt_d = 32'h0;
		end
		// MAC-side carrier and collision.
		txRxEn_d  = strapDone_q && state_d != lneg_pkg::ST_BREAK
			&& state_d != lneg_pkg::ST_DOWN && state_d != lneg_pkg::ST_WAIT;
		txAct     = macTxEn && txRxEn_q;
		rxAct     = rxActive && txRxEn_q;
		crsOut_d  = spd_q[2] ? rxAct : (rxAct || txAct);
		colOut_d  = !spd_q[2] && rxAct && txAct;
		pinOut_d  = rmiiMode_d ? crsOut_d : colOut_d;
		pinOe_d   = strapDone_q;
		miiEn_d   = strapDone_q && !rmiiMode_d;
		rxErOut_d = rxErIn && txRxEn_q;
	end

	// ==================================================================
	// Registers
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= lneg_pkg::ST_WAIT; awready_q <= 1'b0; wready_q <= 1'b0;
			bvalid_q <= 1'b0;   bresp_q <= 2'h0;    arready_q <= 1'b0;  rvalid_q <= 1'b0;
			rresp_q <= 2'h0;    rdata_q <= 32'h0;   wData_q <= 32'h0;   awIdx_q <= 5'h00;
			wStrb_q <= 4'h0;    awHave_q <= 1'b0;   wHave_q <= 1'b0;    ctrlSpeed_q <= 1'b0;
			ctrlAnEn_q <= 1'b0; ctrlPdn_q <= 1'b0;  ctrlDuplex_q <= 1'b0;
			adv_q <= lneg_pkg::ADV_RST;             lpa_q <= 16'h0000;  lpAnAble_q <= 1'b0;
			pdFault_q <= 1'b0;  spd_q <= 3'h0;      modeLatch_q <= 3'h0; anDone_q <= 1'b0;
			mdixDis_q <= 1'b0;  cnt_q <= 32'h0;     slotCnt_q <= 32'h0; gapCnt_q <= 32'h0;
			swapCnt_q <= 32'h0; slotIdx_q <= 6'h00; ackCnt_q <= 2'h0;   burstOn_q <= 1'b0;
			ackBit_q <= 1'b0;   strapDone_q <= 1'b0; rmiiMode_q <= 1'b0; pinOut_q <= 1'b0;
			pinOe_q <= 1'b0;    crsOut_q <= 1'b0;   colOut_q <= 1'b0;   rxErOut_q <= 1'b0;
			flpTx_q <= 1'b0;    txRxEn_q <= 1'b0;   miiEn_q <= 1'b0;    swap_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d; awready_q <= awready_d; wready_q <= wready_d;
			bvalid_q <= bvalid_d; bresp_q <= bresp_d; arready_q <= arready_d;
			rvalid_q <= rvalid_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
			wData_q <= wData_d; awIdx_q <= awIdx_d; wStrb_q <= wStrb_d;
			awHave_q <= awHave_d; wHave_q <= wHave_d; ctrlSpeed_q <= ctrlSpeed_d;
			ctrlAnEn_q <= ctrlAnEn_d; ctrlPdn_q <= ctrlPdn_d; ctrlDuplex_q <= ctrlDuplex_d;
			adv_q <= adv_d; lpa_q <= lpa_d; lpAnAble_q <= lpAnAble_d;
			pdFault_q <= pdFault_d; spd_q <= spd_d; modeLatch_q <= modeLatch_d;
			anDone_q <= anDone_d; mdixDis_q <= mdixDis_d; cnt_q <= cnt_d;
			slotCnt_q <= slotCnt_d; gapCnt_q <= gapCnt_d; swapCnt_q <= swapCnt_d;
			slotIdx_q <= slotIdx_d; ackCnt_q <= ackCnt_d; burstOn_q <= burstOn_d;
			ackBit_q <= ackBit_d; strapDone_q <= strapDone_d; rmiiMode_q <= rmiiMode_d;
			pinOut_q <= pinOut_d; pinOe_q <= pinOe_d; crsOut_q <= crsOut_d;
			colOut_q <= colOut_d; rxErOut_q <= rxErOut_d; flpTx_q <= flpTx_d;
			txRxEn_q <= txRxEn_d; miiEn_q <= miiEn_d; swap_q <= swap_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign collisionOrInterfaceStrapPinOut = pinOut_q;
	assign collisionOrInterfaceStrapPinOe  = pinOe_q;
	assign referenceClockInputSel = rmiiMode_q;
	assign miiOnlyPinsEn = miiEn_q;
	assign crsOut        = crsOut_q;
	assign rxErOut       = rxErOut_q;
	assign flpTxPulse    = flpTx_q;
	assign txRxEnable    = txRxEn_q;
	assign mdixSwap      = swap_q;

	// ==================================================================
	// Assertions
	sequence s_restart;
		restartGo && ctrlAnEn_d && !ctrlPdn_d;
	endsequence
	sequence s_ackFinal;
		state_q == lneg_pkg::ST_ACK && rxWordValid && rxWord[lneg_pkg::ACK_BIT]
			&& rxWord[8:0] == lpa_q[8:0] && ackCnt_q == 2'(lneg_pkg::ACK_WORDS - 1)
			&& !wrDo && !ctrlPdn_q;
	endsequence

	a_strap_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		strapDone_q |=> $stable(rmiiMode_q)) else $error("interface mode changed after reset");
	a_rmii_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
		strapDone_q && rmiiMode_q |=> collisionOrInterfaceStrapPinOut == crsOut_q)
		else $error("shared pin does not carry carrier in reduced mode");
	a_restart_break: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_restart |=> state_q == lneg_pkg::ST_BREAK && !txRxEn_q)
		else $error("restart did not halt traffic");
	a_break_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(state_q == lneg_pkg::ST_BREAK) |->
		(state_q == lneg_pkg::ST_BREAK || ctrlPdn_q || !ctrlAnEn_q)[*8])
		else $error("break-link wait ended early");
	a_frame_slot: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_q == lneg_pkg::ST_ABL || state_q == lneg_pkg::ST_ACK) && burstOn_q
		&& slotCnt_q == 32'h0 && !slotIdx_q[0] |=> flpTx_q)
		else $error("framing pulse missing");
	a_data_slot: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_q == lneg_pkg::ST_ABL || state_q == lneg_pkg::ST_ACK) && burstOn_q
		&& slotCnt_q == 32'h0 && slotIdx_q[0] |=> flpTx_q == $past(txWord[slotIdx_q[4:1]]))
		else $error("data pulse does not match code word");
	a_resolve_top: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_ackFinal ##0 (adv_q[2] && rxWord[7]) |=> spd_q[1] && anDone_q)
		else $error("100M common mode not preferred over 10M");
	a_pdet_half: assert property (@(posedge sys_clk) disable iff (!resetn)
		state_q == lneg_pkg::ST_ABL && !rxWordValid && (rx100Symbols ^ rxNlp) && !wrDo
		&& !ctrlPdn_q |=> state_q == lneg_pkg::ST_LINK && !spd_q[2] && !lpAnAble_q)
		else $error("parallel detection result wrong");
	a_half_col: assert property (@(posedge sys_clk) disable iff (!resetn)
		!spd_q[2] && txRxEn_q && macTxEn && rxActive |=> colOut_q && crsOut_q)
		else $error("half duplex collision missed");
	a_full_nocol: assert property (@(posedge sys_clk) disable iff (!resetn)
		spd_q[2] && !rxActive |=> !colOut_q && !crsOut_q)
		else $error("full duplex carrier or collision from transmit");
	a_restart_rd0: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_axi_arvalid && arready_q && arIdx == lneg_pkg::IDX_CTRL |=> rvalid_q && !rdata_q[9])
		else $error("restart bit reads back set");
	a_adv_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
		wrDo && awIdx_q == lneg_pkg::IDX_ADV && state_q == lneg_pkg::ST_LINK && signalDetect
		&& !ctrlPdn_q |=> state_q == lneg_pkg::ST_LINK)
		else $error("ability write restarted negotiation");
endmodule

/* File: src/lneg_pkg.sv */
// Constants, register map and state type of the link negotiation block.
package lneg_pkg;
	// ==================================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int BREAK_LINK_MS  = 1200;
	localparam int BREAK_LINK_CYC = BREAK_LINK_MS * (1000000 / CLK_PERIOD_NS);
	localparam int SLOT_NS        = 62500;
	localparam int SLOT_CYC       = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BURST_GAP_US   = 16000;
	localparam int BURST_GAP_CYC  = BURST_GAP_US * (1000 / CLK_PERIOD_NS);
	localparam int BURST_TMO_MS   = 50;
	localparam int BURST_TMO_CYC  = BURST_TMO_MS * (1000000 / CLK_PERIOD_NS);
	localparam int MDIX_MS        = 60;
	localparam int MDIX_CYC       = MDIX_MS * (1000000 / CLK_PERIOD_NS);
	localparam int FLP_SLOTS      = 33;
	localparam int ACK_WORDS      = 3;
	// ==================================================================
	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_CTRL  = 5'h00;
	localparam logic [4:0] IDX_ADV   = 5'h04;
	localparam logic [4:0] IDX_LPA   = 5'h05;
	localparam logic [4:0] IDX_EXP   = 5'h06;
	localparam logic [4:0] IDX_VMODE = 5'h11;
	localparam logic [4:0] IDX_SPD   = 5'h1F;
	// ==================================================================
	// Field positions
	localparam int CTRL_RST     = 15;
	localparam int CTRL_SPEED   = 13;
	localparam int CTRL_ANEN    = 12;
	localparam int CTRL_PDN     = 11;
	localparam int CTRL_RESTART = 9;
	localparam int CTRL_DUPLEX  = 8;
	localparam int ADV_LSB      = 5;
	localparam int ACK_BIT      = 14;
	localparam int EXP_LPAN     = 0;
	localparam int EXP_PDF      = 4;
	localparam int SPD_LSB      = 2;
	localparam int SPD_DONE     = 12;
	localparam int VMODE_MDIXDIS = 0;
	// ==================================================================
	// Encodings and reset values
	localparam logic [4:0] SELECTOR = 5'h01;
	localparam logic [2:0] SPD_10H  = 3'h1;
	localparam logic [2:0] SPD_100H = 3'h2;
	localparam logic [2:0] SPD_10F  = 3'h5;
	localparam logic [2:0] SPD_100F = 3'h6;
	localparam logic [3:0] ADV_RST  = 4'hF;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [2:0] {ST_WAIT, ST_DOWN, ST_FORCED, ST_BREAK, ST_ABL, ST_ACK, ST_LINK}
		lneg_state_e;
endpackage

/* File: dv/lneg_partner.sv */
// Remote link partner model that answers with a code word burst sequence.
module lneg_partner (
	input  wire logic        sys_clk,
	input  wire logic        go,
	input  wire logic [15:0] word,
	output logic             rxWordValid,
	output logic [15:0]      rxWord,
	output logic             signalDetect
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==============================================================
	// One plain word, then acknowledged copies with unchanged content.
	initial
	begin
		rxWordValid = 1'b0;
		rxWord = 16'h0000;
		signalDetect = 1'b0;
		forever
		begin
			@(posedge sys_clk);
			if (go)
			begin
				signalDetect <= 1'b1;
				for (int i = 0; i < 4; i++)
				begin
					rxWord <= (i > 0) ? (word | 16'h4000) : word;
					rxWordValid <= 1'b1;
					@(posedge sys_clk);
					rxWordValid <= 1'b0;
					// An idle word bus must not look like the last valid word.
					rxWord <= ~rxWord;
					repeat (40) @(posedge sys_clk);
				end
			end
		end
	end
endmodule

/* File: dv/tb_link_autonegotiation.sv */
// Self-checking bench for the link negotiation core.
module tb_link_autonegotiation;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, resetn, go, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, macTxEn, rxActive, rxErIn, crsOut, rxErOut;
	logic        collisionOrInterfaceStrapPinIn, collisionOrInterfaceStrapPinOut;
	logic        collisionOrInterfaceStrapPinOe, referenceClockInputSel, miiOnlyPinsEn;
	logic        flpTxPulse, rxWordValid, rx100Symbols, rxNlp, signalDetect, txRxEnable;
	logic        mdixSwap, s;
	logic [6:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [15:0] word, rxWord;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  modeStrap;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	int          failures = 0;
	int          checks_done = 0;
	int          n, t;
	lneg_core #(.BREAK_CYC(20), .SLOT_CYCS(4), .GAP_CYC(200), .TMO_CYC(2000), .SWAP_CYC(50))
		i_dut (.*);
	lneg_partner i_partner (.*);
	// ==============================================================
	// Clock, watchdog and tasks
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		failures++;
		print_verdict();
	end
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] i, input logic [31:0] v);
		@(posedge sys_clk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		repeat (200)
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		failures++;
		print_verdict();
	endtask
	task automatic rd(input logic [4:0] i);
		@(posedge sys_clk);
		s_axi_araddr <= {i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		repeat (200)
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				{d, resp} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'b0;
				return;
			end
		end
		failures++;
		print_verdict();
	endtask
	// ==============================================================
	// Main sequence
	initial
	begin
		{resetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, macTxEn, rxActive, rxErIn, rx100Symbols, rxNlp} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{collisionOrInterfaceStrapPinIn, modeStrap, s_axi_wstrb} = 8'hFF;
		word = 16'h00A1;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("refclk", {referenceClockInputSel, miiOnlyPinsEn, collisionOrInterfaceStrapPinOe},
			3'h5);
		rd(lneg_pkg::IDX_VMODE);
		chk("rmii", d[1], 1'h1);
		rd(lneg_pkg::IDX_ADV);
		chk("adv", d[8:0], 9'h1E1);
		rd(5'h07);
		chk("unmapped", resp, lneg_pkg::RESP_ERR);
		// One burst period is 33 slots of 4 cycles plus a 200 cycle gap: 17 framing
		// pulses and the five set code word bits; the idle crossover hunt flips every 50.
		n = 0;
		t = 0;
		s = mdixSwap;
		for (int k = 0; k < 332; k++)
		begin
			@(posedge sys_clk);
			n += flpTxPulse;
			t += (mdixSwap != s);
			s = mdixSwap;
		end
		chk("pulses", n, 22);
		chk("swaps", t, 6);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (60)
		begin
			rd(lneg_pkg::IDX_SPD);
			if (d[12])
				break;
		end
		chk("speed", {d[12], d[4:2]}, {1'h1, lneg_pkg::SPD_100H});
		rd(lneg_pkg::IDX_LPA);
		chk("partner", d[8:0], 9'h0A1);
		{macTxEn, rxErIn} <= 2'h3;
		repeat (3) @(posedge sys_clk);
		chk("crs half", crsOut, 1'h1);
		chk("crs pin", collisionOrInterfaceStrapPinOut, 1'h1);
		chk("rx error", rxErOut, 1'h1);
		rxActive <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rxActive <= 1'b0;
		wr(lneg_pkg::IDX_CTRL, 32'h00001200);
		repeat (2) @(posedge sys_clk);
		chk("break", txRxEnable, 1'h0);
		rd(lneg_pkg::IDX_CTRL);
		chk("restart", d[9], 1'h0);
		// The partner has gone quiet; after the break wait only line symbols are seen.
		repeat (20) @(posedge sys_clk);
		rx100Symbols <= 1'b1;
		@(posedge sys_clk);
		rx100Symbols <= 1'b0;
		rd(lneg_pkg::IDX_EXP);
		chk("pdet able", d[4:0], 5'h00);
		rd(lneg_pkg::IDX_LPA);
		chk("pdet partner", d[15:0], 16'h0081);
		wr(lneg_pkg::IDX_ADV, 32'h00000020);
		rd(lneg_pkg::IDX_SPD);
		chk("pdet speed", {d[12], d[4:2]}, {1'h1, lneg_pkg::SPD_100H});
		rd(lneg_pkg::IDX_ADV);
		chk("adv write", d[8:0], 9'h021);
		wr(lneg_pkg::IDX_CTRL, 32'h00002100);
		rd(lneg_pkg::IDX_SPD);
		chk("forced", d[4:2], lneg_pkg::SPD_100F);
		chk("crs full", crsOut, 1'h0);
		// Second reset: low interface strap, negotiation strapped off at 100M half.
		{resetn, collisionOrInterfaceStrapPinIn, modeStrap, rxActive} <= 6'h05;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk("mii col", {miiOnlyPinsEn, collisionOrInterfaceStrapPinOut}, 2'h3);
		rd(lneg_pkg::IDX_SPD);
		chk("strap forced", {d[12], d[4:2]}, {1'h0, lneg_pkg::SPD_100H});
		print_verdict();
	end
endmodule
